// ==== core/segment_lcd_frame_timing.sv ====
// Behaviour
// - frame rate from prescale and multiplex setting
// - static frame is four prescaled units
// - half multiplex frame is two by two units
// - third multiplex frame is three units
// - quarter multiplex frame is four units
// - every pixel waveform carries no DC
// - set bit dark, cleared bit clear
// - Type-A inverts phase inside each slice
// - Type-B inverts phase at frame boundaries
// - frame starts at first common slice
// - irq flag set after last row fetch
// - Type-B irq once per frame pair
// - refused pixel write sets error flag
// - no irq for Type-A or static Type-B
// - sleep-stop bit selects halt in sleep
// - halt in sleep drives minimum level
// - keep displaying in sleep when allowed
// - pixel memory frozen during sleep
// - system clock source always halts in sleep
// - common count field resets to static
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps

`include "segment_lcd_frame_timing_defines.svh"

module segment_lcd_frame_timing
  import segment_lcd_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire apb_req_t apb_req,
  output apb_resp_t     apb_resp,
  input  wire logic     timing_tick,
  input  wire logic     cpu_sleep,
  output drive_t        drive,
  output logic          frame_irq_flag,
  output logic          write_window
);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    logic [2:0] s;
    s = `SEL_NONE;
    if (a == `OFF_DISPLAY_CONTROL) begin
      s = `SEL_CTRL;
    end else if (a == `OFF_FRAME_PRESCALE) begin
      s = `SEL_PRESCALE;
    end else if (a == `OFF_FRAME_STATUS) begin
      s = `SEL_STATUS;
    end else if ((a & `PIXEL_ADDR_MASK) == `OFF_PIXEL_BASE && a[1:0] == 2'h0) begin
      s = `SEL_PIXEL;
    end
    return s;
  endfunction

  // prescaled units per common slice
  function automatic logic [2:0] slice_units(input logic [1:0] mux);
    logic [2:0] u;
    case (mux)
      2'h0:    u = `SLICE_UNITS_STATIC;
      2'h1:    u = `SLICE_UNITS_HALF;
      default: u = `SLICE_UNITS_MULTI;
    endcase
    return u;
  endfunction

  // drive level per line; pol flips every level so each pair of phases cancels
  function automatic logic [1:0] level_code(input logic is_static, input logic is_com,
                                            input logic active, input logic pol);
    logic [1:0] lv;
    lv = `LVL_V0;
    if (is_static) begin
      lv = (pol ^ (!is_com && active)) ? `LVL_V3 : `LVL_V0;
    end else if (is_com) begin
      lv = active ? (pol ? `LVL_V0 : `LVL_V3) : (pol ? `LVL_V2 : `LVL_V1);
    end else begin
      lv = active ? (pol ? `LVL_V3 : `LVL_V0) : (pol ? `LVL_V1 : `LVL_V2);
    end
    return lv;
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  state_t     st_reg;
  state_t     st_next;
  logic       halt_w;
  logic       setup_w;
  logic       access_w;
  logic [2:0] sel_w;
  logic       multi_w;
  logic       wr_ok_w;
  logic [6:0] slice_len;
  logic       cfg_write_w;
  logic       adv_w;
  logic       wrap_w;
  logic       start_w;
  logic       pol_w;

  assign apb_resp       = st_reg.resp;
  assign drive          = st_reg.drive;
  assign frame_irq_flag = st_reg.irq;
  assign write_window   = st_reg.window;

  always_comb begin
    st_next     = st_reg;
    halt_w      = cpu_sleep && (st_reg.ctrl.sleep_stop_ctrl
                  || st_reg.ctrl.clock_source == `CLK_SRC_SYSTEM);
    setup_w     = apb_req.psel && !apb_req.penable;
    access_w    = apb_req.psel && apb_req.penable && st_reg.resp.pready;
    sel_w       = reg_sel(apb_req.paddr);
    multi_w     = st_reg.ctrl.common_count_select != `MUX_STATIC;
    // sleep freezes the image; paired frames accept data only in the window
    wr_ok_w     = !cpu_sleep && (!(st_reg.ctrl.type_b && multi_w) || st_reg.window);
    slice_len   = {4'h0, slice_units(st_reg.ctrl.common_count_select)}
                  * ({3'h0, st_reg.prescale} + 7'h01);
    cfg_write_w = access_w && apb_req.pwrite && (sel_w == `SEL_CTRL || sel_w == `SEL_PRESCALE);
    adv_w       = 1'b0;
    wrap_w      = 1'b0;
    start_w     = 1'b0;
    pol_w       = 1'b0;

    // ------------------------------------------------------------------------
    // apb slave: no wait state, read data captured in the setup cycle, write data in the access cycle
    // ------------------------------------------------------------------------
    st_next.resp.pready  = setup_w;
    st_next.resp.pslverr = setup_w && (sel_w == `SEL_NONE);
    st_next.resp.prdata  = 32'h0000_0000;
    if (setup_w) begin
      case (sel_w)
        `SEL_CTRL:     st_next.resp.prdata = {24'h00_0000, st_reg.ctrl};
        `SEL_PRESCALE: st_next.resp.prdata = {28'h000_0000, st_reg.prescale};
        `SEL_STATUS:   st_next.resp.prdata = {26'h000_0000, st_reg.slice, 1'b0,
                                              st_reg.parity, st_reg.window, st_reg.irq};
        `SEL_PIXEL:    st_next.resp.prdata = st_reg.pix[apb_req.paddr[3:2]];
        default:       st_next.resp.prdata = 32'h0000_0000;
      endcase
    end
    if (access_w && apb_req.pwrite) begin
      case (sel_w)
        `SEL_CTRL: begin
          st_next.ctrl = ctrl_t'(apb_req.pwdata[7:0]);
          st_next.ctrl.write_error_flag = st_reg.ctrl.write_error_flag
                                          && !apb_req.pwdata[`CTRL_WRITE_ERROR_FLAG_BIT];
        end
        `SEL_PRESCALE: st_next.prescale = apb_req.pwdata[3:0];
        `SEL_STATUS:   st_next.irq = st_reg.irq && !apb_req.pwdata[`STATUS_IRQ_BIT];
        `SEL_PIXEL: begin
          if (wr_ok_w) begin
            st_next.pix[apb_req.paddr[3:2]] = apb_req.pwdata;
          end else begin
            st_next.ctrl.write_error_flag = 1'b1;
          end
        end
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end

    // ------------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------------
    case (st_reg.mode)
      ST_OFF: begin
        if (st_reg.ctrl.display_enable && !halt_w) begin
          st_next.mode = ST_RUN;
          start_w      = 1'b1;
        end
      end
      ST_RUN: begin
        if (!st_reg.ctrl.display_enable) begin
          st_next.mode = ST_OFF;
        end else if (halt_w) begin
          st_next.mode = ST_HALT;
        end else begin
          adv_w = timing_tick;
        end
      end
      ST_HALT: begin
        if (!st_reg.ctrl.display_enable) begin
          st_next.mode = ST_OFF;
        end else if (!halt_w) begin
          st_next.mode = ST_RUN;
        end
      end
      default: st_next.mode = ST_OFF;
    endcase

    // ------------------------------------------------------------------------
    // slice and frame sequencer; a row is fetched at the start of its slice
    // ------------------------------------------------------------------------
    if (start_w) begin
      st_next.tick_cnt = 7'h00;
      st_next.slice    = 2'h0;
      st_next.parity   = 1'b0;
      st_next.window   = 1'b0;
      st_next.row      = st_reg.pix[0];
    end
    if (adv_w) begin
      if (st_reg.tick_cnt >= slice_len - 7'h01) begin
        st_next.tick_cnt = 7'h00;
        if (st_reg.slice >= st_reg.ctrl.common_count_select) begin
          wrap_w         = 1'b1;
          st_next.slice  = 2'h0;
          st_next.parity = !st_reg.parity;
          st_next.window = 1'b0;
        end else begin
          st_next.slice = st_reg.slice + 2'h1;
        end
        st_next.row = st_reg.pix[st_next.slice];
        // last row of the odd frame fetched: the pair is complete
        if (st_next.slice == st_reg.ctrl.common_count_select && st_reg.ctrl.type_b
            && multi_w && st_next.parity) begin
          st_next.irq    = 1'b1;
          st_next.window = 1'b1;
        end
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt + 7'h01;
      end
    end
    if (st_next.mode == ST_OFF) begin
      st_next.window = 1'b0;
    end

    // ------------------------------------------------------------------------
    // waveform; odd-length Type-A slices split unevenly, so the split order
    // also swaps every frame and the residue cancels over two frames
    // ------------------------------------------------------------------------
    if (st_reg.ctrl.type_b) begin
      pol_w = st_next.parity;
    end else begin
      pol_w = (st_next.tick_cnt >= (slice_len >> 1)) ^ st_next.parity;
    end
    for (int i = 0; i < 4; i++) begin
      st_next.drive.com[i] = (2'(i) <= st_reg.ctrl.common_count_select)
                             ? level_code(!multi_w, 1'b1, st_next.slice == 2'(i), pol_w)
                             : `LVL_V0;
    end
    for (int j = 0; j < 32; j++) begin
      st_next.drive.column_drive_lines[j] = level_code(!multi_w, 1'b0, st_next.row[j], pol_w);
    end
    if (st_next.mode != ST_RUN) begin
      st_next.drive = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic [7:0] frame_ticks;
  logic       cfg_stable;
  logic [7:0] frame_expect;

  assign frame_expect = ((st_reg.ctrl.common_count_select == `MUX_THIRD) ? `FRAME_UNITS_THIRD
                        : `FRAME_UNITS_OTHER) * ({4'h0, st_reg.prescale} + 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ticks <= 8'h00;
      cfg_stable  <= 1'b0;
    end else begin
      if (start_w || wrap_w) begin
        frame_ticks <= 8'h00;
        cfg_stable  <= 1'b1;
      end else if (adv_w) begin
        frame_ticks <= frame_ticks + 8'h01;
      end
      if (cfg_write_w) begin
        cfg_stable <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_frame_length: assert property (
    wrap_w && cfg_stable && !cfg_write_w |-> (frame_ticks + 8'h01) == frame_expect)
    else $error("frame length differs from prescale setting");

  chk_halt_sleep_stop: assert property (
    cpu_sleep && st_reg.ctrl.sleep_stop_ctrl |=> st_reg.drive == '0 && st_reg.mode != ST_RUN)
    else $error("sleep with stop set did not halt at minimum level");

  chk_halt_sys_clock: assert property (
    cpu_sleep && st_reg.ctrl.clock_source == `CLK_SRC_SYSTEM |=> st_reg.drive == '0)
    else $error("system clock source kept driving in sleep");

  chk_sleep_keeps_run: assert property (
    cpu_sleep && !halt_w && st_reg.mode == ST_RUN && st_reg.ctrl.display_enable
    && !cfg_write_w |=> st_reg.mode == ST_RUN)
    else $error("display stopped in sleep although allowed to run");

  chk_pixels_frozen: assert property (
    cpu_sleep |=> $stable(st_reg.pix))
    else $error("pixel memory changed during sleep");

  chk_write_error_flag_set: assert property (
    access_w && apb_req.pwrite && sel_w == `SEL_PIXEL && !wr_ok_w
    |=> st_reg.ctrl.write_error_flag && $stable(st_reg.pix))
    else $error("refused pixel write did not raise error flag");

  chk_no_irq_type_a: assert property (
    !st_reg.irq && (!st_reg.ctrl.type_b || !multi_w) |=> !st_reg.irq)
    else $error("frame irq raised in a mode without irq");

  chk_irq_odd_frame: assert property (
    $rose(st_reg.irq) |-> st_reg.parity && st_reg.window
    && st_reg.slice == $past(st_reg.ctrl.common_count_select))
    else $error("frame irq outside last slice of odd frame");

  chk_parity_toggle: assert property (
    wrap_w |=> st_reg.parity != $past(st_reg.parity) ##1 $stable(st_reg.parity) || wrap_w)
    else $error("frame parity did not toggle at boundary");

  chk_window_close: assert property (
    wrap_w |=> !st_reg.window && st_reg.slice == 2'h0)
    else $error("write window open after first fetch of frame");

  chk_fetch_row: assert property (
    wrap_w |=> st_reg.row == $past(st_reg.pix[0]))
    else $error("first common row not fetched at frame start");

  chk_typeb_com_pol: assert property (
    st_reg.mode == ST_RUN && st_reg.ctrl.type_b && multi_w && st_reg.slice == 2'h0
    && $stable(st_reg.ctrl) |-> st_reg.drive.com[0] == (st_reg.parity ? `LVL_V0 : `LVL_V3))
    else $error("Type-B common polarity not tied to frame parity");

  cov_irq_raised: cover property ($rose(st_reg.irq));
  cov_write_error_flag: cover property ($rose(st_reg.ctrl.write_error_flag));
  cov_halt: cover property (st_reg.mode == ST_RUN ##1 st_reg.mode == ST_HALT);
  cov_sleep_run: cover property (cpu_sleep && st_reg.mode == ST_RUN && wrap_w);

endmodule

// ==== include/segment_lcd_frame_timing_defines.svh ====
`ifndef SEGMENT_LCD_FRAME_TIMING_DEFINES_SVH
`define SEGMENT_LCD_FRAME_TIMING_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFF_DISPLAY_CONTROL 12'h000
`define OFF_FRAME_PRESCALE  12'h004
`define OFF_FRAME_STATUS    12'h008
`define OFF_PIXEL_BASE      12'h010
`define PIXEL_ADDR_MASK     12'hff0

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL_WRITE_ERROR_FLAG_BIT       5
`define CTRL_SLEEP_BIT      6
`define STATUS_IRQ_BIT      0
`define CTRL_RESET          8'h00
`define PRESCALE_RESET      4'h0

// ----------------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------------
`define CLK_SRC_SYSTEM      2'h0
`define MUX_STATIC          2'h0
`define MUX_THIRD           2'h2
`define LVL_V0              2'h0
`define LVL_V1              2'h1
`define LVL_V2              2'h2
`define LVL_V3              2'h3
`define SEL_NONE            3'h0
`define SEL_CTRL            3'h1
`define SEL_PRESCALE        3'h2
`define SEL_STATUS          3'h3
`define SEL_PIXEL           3'h4

// ----------------------------------------------------------------------------
// timing counts, in prescaled units of the timing tick
// ----------------------------------------------------------------------------
`define SLICE_UNITS_STATIC  3'h4
`define SLICE_UNITS_HALF    3'h2
`define SLICE_UNITS_MULTI   3'h1
`define FRAME_UNITS_THIRD   8'h03
`define FRAME_UNITS_OTHER   8'h04

`endif

// ==== include/segment_lcd_pkg.sv ====
package segment_lcd_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_HALT
  } run_state_t;

  typedef struct packed {
    logic       display_enable;
    logic       sleep_stop_ctrl;
    logic       write_error_flag;
    logic       type_b;
    logic [1:0] clock_source;
    logic [1:0] common_count_select;
  } ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_resp_t;

  typedef struct packed {
    logic [3:0][1:0]  com;
    logic [31:0][1:0] column_drive_lines;
  } drive_t;

  typedef struct packed {
    run_state_t       mode;
    ctrl_t            ctrl;
    logic [3:0]       prescale;
    logic [3:0][31:0] pix;
    logic [31:0]      row;
    logic [6:0]       tick_cnt;
    logic [1:0]       slice;
    logic             parity;
    logic             irq;
    logic             window;
    drive_t           drive;
    apb_resp_t        resp;
  } state_t;

endpackage

// ==== verification/lcd_glass_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// passive glass: integrates two pixels on common 0
// ----------------------------------------------------------------------------
module lcd_glass_model
  import segment_lcd_pkg::*;
(
  input  wire logic   pclk,
  input  wire drive_t drive,
  output logic        frame_edge,
  output int          dc_dark,
  output int          dc_clear,
  output int          sq_dark,
  output int          sq_clear
);
  logic [1:0] first_common_line_q = 2'h0;
  int         acc_d  = 0;
  int         acc_c  = 0;
  int         sqa_d  = 0;
  int         sqa_c  = 0;
  int         v_d;
  int         v_c;

  // frame start: common 0 enters a selected level
  assign frame_edge = (drive.com[0] !== first_common_line_q) && (drive.com[0] inside {2'h0, 2'h3});
  assign v_d        = int'(drive.com[0]) - int'(drive.column_drive_lines[0]);
  assign v_c        = int'(drive.com[0]) - int'(drive.column_drive_lines[1]);
  assign dc_dark    = acc_d;
  assign dc_clear   = acc_c;
  assign sq_dark    = sqa_d;
  assign sq_clear   = sqa_c;

  // cycle weighted, so ticks must be steady while sums are taken
  always @(posedge pclk) begin
    first_common_line_q <= drive.com[0];
    acc_d  <= acc_d + v_d;
    acc_c  <= acc_c + v_c;
    sqa_d  <= sqa_d + v_d * v_d;
    sqa_c  <= sqa_c + v_c * v_c;
  end
endmodule

// ==== verification/segment_lcd_frame_timing_bench.sv ====
`timescale 1ns/100ps

module segment_lcd_frame_timing_bench
  import segment_lcd_pkg::*;
;
  logic        pclk;
  logic        presetn;
  apb_req_t    apb_req;
  apb_resp_t   apb_resp;
  logic        timing_tick;
  logic        cpu_sleep;
  drive_t      drive;
  logic        frame_irq_flag;
  logic        write_window;
  logic        frame_edge;
  logic        tick_rand;
  int          dc_dark, dc_clear, sq_dark, sq_clear;
  int          err_total, n_compared, seed, cyc, tick_cnt, last_tick, d0, d1, s0, s1, n, n_fe;
  logic [3:0]  p;
  logic [31:0] pix[4];
  logic [32:0] exp_q[$];
  int          fr_q[$];

  segment_lcd_frame_timing DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_resp(apb_resp),
    .timing_tick(timing_tick), .cpu_sleep(cpu_sleep), .drive(drive), .frame_irq_flag(frame_irq_flag),
    .write_window(write_window));

  lcd_glass_model glass (.pclk(pclk), .drive(drive), .frame_edge(frame_edge), .dc_dark(dc_dark),
    .dc_clear(dc_clear), .sq_dark(sq_dark), .sq_clear(sq_clear));

  // ----------------------------------------------------------------------------
  // clock, tick, timeout
  // ----------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    timing_tick <= tick_rand ? 1'($random(seed)) : 1'b1;
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------------------
  always @(posedge pclk) begin
    if (apb_req.psel && apb_req.penable && apb_resp.pready === 1'b1 && !apb_req.pwrite)
      check({apb_resp.pslverr, apb_resp.prdata}, exp_q.pop_front());
    if (frame_edge) begin
      if (fr_q.size() > 0) check(tick_cnt - last_tick, fr_q.pop_front());
      last_tick = tick_cnt;
      n_fe++;
    end
    if (timing_tick) tick_cnt++;
  end

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_resp.pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (k >= 50) err_total++;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic edges_wait(input int k);
    int g;
    g = 0;
    while (k > 0 && g < 5000) begin
      @(posedge pclk);
      g++;
      if (frame_edge) k--;
    end
    if (k > 0) err_total++;
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] cs, input logic tb, input logic ss);
    return {24'h0, 1'b1, ss, 1'b0, tb, cs, m};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    seed = 35;
    apb_req = '0;
    presetn = 1'b0;
    cpu_sleep = 1'b0;
    tick_rand = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 33'h0);
    rd(12'h004, 33'h0);
    rd(12'h00c, 33'h100000000);
    for (int c = 0; c < 4; c++) begin
      pix[c] = $random(seed);
      if (c == 0) pix[c][1:0] = 2'b01;
      wr(12'h010 + 12'(4 * c), pix[c]);
    end
    rd(12'h010, {1'b0, pix[0]});
    // every multiplex setting, random prescale and tick spacing
    for (int m = 0; m < 4; m++) begin
      p = 4'($random(seed)) & 4'h3;
      wr(12'h004, {28'h0, p});
      wr(12'h008, 32'h1);
      wr(12'h000, ctl(2'(m), 2'h1, 1'b1, 1'b0));
      tick_rand <= 1'b1;
      edges_wait(1);
      @(posedge pclk);
      repeat (2) fr_q.push_back((m == 2 ? 3 : 4) * (int'(p) + 1));
      edges_wait(2);
      tick_rand <= 1'b0;
      edges_wait(1);
      d0 = dc_dark;
      d1 = dc_clear;
      s0 = sq_dark;
      s1 = sq_clear;
      edges_wait(2);
      check(dc_dark - d0, 0);
      check(dc_clear - d1, 0);
      check(sq_dark - s0 > sq_clear - s1, 1);
      check(frame_irq_flag, m != 0);
      wr(12'h000, 32'h0);
    end
    // write window in multiplexed second style drive
    wr(12'h004, 32'h7);
    wr(12'h008, 32'h1);
    wr(12'h000, ctl(2'h3, 2'h1, 1'b1, 1'b0));
    edges_wait(1);
    check(write_window, 1'b0);
    wr(12'h014, ~pix[1]);
    rd(12'h014, {1'b0, pix[1]});
    rd(12'h000, {1'b0, ctl(2'h3, 2'h1, 1'b1, 1'b0) | 32'h20});
    n = 0;
    while (frame_irq_flag !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check(write_window, 1'b1);
    n = n_fe;
    pix[1] = ~pix[1];
    wr(12'h014, pix[1]);
    rd(12'h014, {1'b0, pix[1]});
    wr(12'h008, 32'h1);
    while (frame_irq_flag !== 1'b1 && n_fe - n < 4) begin
      @(posedge pclk);
    end
    check(n_fe - n, 2);
    // first style drive never interrupts
    wr(12'h000, ctl(2'h3, 2'h1, 1'b0, 1'b0) | 32'h20);
    wr(12'h008, 32'h1);
    edges_wait(6);
    check(frame_irq_flag, 1'b0);
    // sleep with a slow source keeps running, memory frozen
    wr(12'h000, ctl(2'h3, 2'h1, 1'b1, 1'b0));
    edges_wait(1);
    cpu_sleep <= 1'b1;
    edges_wait(1);
    @(posedge pclk);
    repeat (2) fr_q.push_back(32);
    edges_wait(2);
    wr(12'h018, ~pix[2]);
    rd(12'h018, {1'b0, pix[2]});
    rd(12'h000, {1'b0, ctl(2'h3, 2'h1, 1'b1, 1'b0) | 32'h20});
    wr(12'h000, ctl(2'h3, 2'h1, 1'b1, 1'b1));
    @(posedge pclk);
    check(drive, 72'h0);
    // system clock source halts whatever the stop bit says
    cpu_sleep <= 1'b0;
    wr(12'h000, ctl(2'h3, 2'h0, 1'b1, 1'b0));
    edges_wait(2);
    cpu_sleep <= 1'b1;
    repeat (2) @(posedge pclk);
    check(drive, 72'h0);
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule
